// ===== hdl/wdt_top.sv
// wdt_top: watchdog / interval timer with shared clock select and sticky mode register.
// assumes i_clk is the main system clock fxx and that all inputs are synchronous to it;
// the cpu applies at most one access per cycle through i_bus.
`timescale 1ns/1ps
module wdt_top #(
	parameter int CNT_W = wdt_pkg::WDT_CNT_W,
	parameter int PRESC_W = wdt_pkg::WDT_PRESC_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// cpu register access
	input wire wdt_pkg::wdt_bus_req_t i_bus,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	// standby and cpu clock status
	input wire logic i_halt_standby,
	input wire logic i_stop_standby,
	input wire logic i_cpu_on_subclock,
	// interrupt flags of the periodic request
	input wire logic i_periodic_irq_mask,
	input wire logic i_periodic_irq_priority,
	// requests to core and interrupt logic
	output wdt_pkg::wdt_irq_t o_irq,
	// pass-through fields for watch timer and buzzer
	output logic o_watch_clock_sel,
	output logic [2:0] o_buzzer_freq_sel
);
	import wdt_pkg::*;

	// tick test: low (base+code) prescaler bits all ones, code 111 needs one extra bit
	function automatic logic tick_of(input logic [2:0] code, input logic [PRESC_W-1:0] presc);
		int n;
		logic all_ones;
		n = WDT_DIV_BASE + int'(code) + ((code == WDT_CODE_LONG) ? 1 : 0);
		all_ones = 1'b1;
		for (int i = 0; i < PRESC_W; i++) begin
			if (i < n && !presc[i]) begin
				all_ones = 1'b0;
			end
		end
		return all_ones;
	endfunction : tick_of

	// register storage
	logic [7:0] clk_sel; // shared clock select register
	logic action_sel; // overflow_action_select
	logic runaway_sel; // runaway_mode_select
	wdt_state_t state; // counting or not (restart bit view)
	logic [PRESC_W-1:0] presc; // free running prescaler
	logic [CNT_W-1:0] cnt; // watchdog count
	wdt_irq_t irq; // registered requests
	logic [7:0] rd_data;
	logic rd_valid;

	// decoded access strobes
	wire hit_cs = (i_bus.addr == WDT_ADDR_CLK_SEL);
	wire hit_mode = (i_bus.addr == WDT_ADDR_MODE);
	// byte writes only; single-bit writes to the clock select are dropped
	wire cs_wr = hit_cs && i_bus.byte_wr;
	wire mode_byte = hit_mode && i_bus.byte_wr;
	wire mode_bit = hit_mode && i_bus.bit_wr;
	// bit value seen at each mode position for this access
	wire set_action = (mode_byte && i_bus.wdata[WDT_MODE_ACTION_BIT])
		|| (mode_bit && i_bus.bit_val && i_bus.bit_sel == 3'(WDT_MODE_ACTION_BIT));
	wire set_runaway = (mode_byte && i_bus.wdata[WDT_MODE_RUNAWAY_BIT])
		|| (mode_bit && i_bus.bit_val && i_bus.bit_sel == 3'(WDT_MODE_RUNAWAY_BIT));
	// every write of one restarts, a write of zero does nothing
	wire restart = (mode_byte && i_bus.wdata[WDT_MODE_RUN_BIT])
		|| (mode_bit && i_bus.bit_val && i_bus.bit_sel == 3'(WDT_MODE_RUN_BIT));

	// counting stops with the oscillator and while the cpu runs from the subclock
	wire osc_run = !i_stop_standby;
	wire cnt_en = osc_run && !i_cpu_on_subclock && (state == WDT_ST_RUN);
	// watchdog count clock from the selected divide ratio
	wire [2:0] wd_code = clk_sel[WDT_CS_WD_LSB +: 3];
	wire tick = tick_of(wd_code, presc);
	wire cnt_full = (cnt == {CNT_W{1'b1}});
	wire overflow = cnt_en && tick && cnt_full && !restart;
	// overflow actions by mode; halt standby is deliberately not looked at
	wire wd_mode = runaway_sel;
	wire next_nmi = overflow && wd_mode && !action_sel;
	wire next_reset = overflow && wd_mode && action_sel;
	wire next_periodic = overflow && !wd_mode && action_sel && !i_periodic_irq_mask;
	wire unused_halt = i_halt_standby;
	// mode register read view
	wire [7:0] mode_view = {(state == WDT_ST_RUN), 2'b00, runaway_sel, action_sel, 3'b000};
	wire [7:0] next_rd_data = hit_cs ? clk_sel : (hit_mode ? mode_view : 8'h00);

	// shared clock select register; bit 3 held at zero
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			clk_sel <= WDT_CLK_SEL_RST;
		end else if (cs_wr) begin
			clk_sel <= i_bus.wdata & WDT_CLK_SEL_MASK;
		end
	end

	// sticky mode bits: software can set them, only reset clears them
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			action_sel <= WDT_MODE_RST[WDT_MODE_ACTION_BIT];
			runaway_sel <= WDT_MODE_RST[WDT_MODE_RUNAWAY_BIT];
		end else begin
			action_sel <= action_sel || set_action;
			runaway_sel <= runaway_sel || set_runaway;
		end
	end

	// run state: once started nothing but reset returns it to idle
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= WDT_ST_IDLE;
		end else begin
			case (state)
				WDT_ST_IDLE: begin
					if (restart) begin
						state <= WDT_ST_RUN;
					end
				end
				WDT_ST_RUN: begin
					state <= WDT_ST_RUN;
				end
				default: begin
					state <= WDT_ST_IDLE;
				end
			endcase
		end
	end

	// prescaler runs with the oscillator and is never cleared by a restart,
	// so the first period after a restart may come short by up to one count clock
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			presc <= WDT_PRESC_RST;
		end else if (osc_run) begin
			presc <= presc + PRESC_W'(1);
		end
	end

	// watchdog counter: restart wins over an overflow in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt <= '0;
		end else if (restart) begin
			cnt <= '0;
		end else if (cnt_en && tick) begin
			cnt <= cnt + CNT_W'(1);
		end
	end

	// one-cycle requests; the priority flag is passed on as a level
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			irq <= '0;
		end else begin
			irq.nmi <= next_nmi;
			irq.sys_reset <= next_reset;
			irq.periodic_irq <= next_periodic;
			irq.periodic_irq_priority <= i_periodic_irq_priority;
		end
	end

	// registered read answer, one cycle after the read
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_data <= i_bus.rd ? next_rd_data : rd_data;
			rd_valid <= i_bus.rd;
		end
	end

	// outputs
	assign o_irq = irq;
	assign o_rd_data = rd_data;
	assign o_rd_valid = rd_valid;
	assign o_watch_clock_sel = clk_sel[WDT_CS_WATCH_BIT];
	assign o_buzzer_freq_sel = clk_sel[WDT_CS_BUZ_LSB +: 3];
endmodule : wdt_top

// ===== hdl/wdt_pkg.sv
// wdt_pkg: constants, register layout and carrier types of the watchdog / interval timer.
// assumes one main clock that is also the count source; bus is the cpu's 8-bit byte/bit write port.
package wdt_pkg;
	// register addresses in the cpu's special register space
	localparam logic [15:0] WDT_ADDR_CLK_SEL = 16'hFF42;
	localparam logic [15:0] WDT_ADDR_MODE = 16'hFFF9;
	// reset values
	localparam logic [7:0] WDT_CLK_SEL_RST = 8'h00;
	localparam logic [7:0] WDT_MODE_RST = 8'h00;
	// clock select fields
	localparam int WDT_CS_WD_LSB = 0;
	localparam int WDT_CS_WATCH_BIT = 4;
	localparam int WDT_CS_BUZ_LSB = 5;
	// writable bits of the clock select register (bit 3 is fixed zero)
	localparam logic [7:0] WDT_CLK_SEL_MASK = 8'hF7;
	// mode register bits
	localparam int WDT_MODE_ACTION_BIT = 3;
	localparam int WDT_MODE_RUNAWAY_BIT = 4;
	localparam int WDT_MODE_RUN_BIT = 7;
	// divide exponents: count clock is fxx / 2^(base + code), code 111 jumps by one more
	localparam int WDT_DIV_BASE = 3;
	localparam logic [2:0] WDT_CODE_LONG = 3'h7;
	// counter length: 2^8 count clocks per overflow, so 2^11..2^17 and 2^19 main clocks
	localparam int WDT_CNT_W = 8;
	localparam int WDT_PRESC_W = 11;
	localparam logic [WDT_PRESC_W-1:0] WDT_PRESC_RST = 11'h000;

	// run state of the counter
	typedef enum logic [1:0] {
		WDT_ST_IDLE = 2'b01,
		WDT_ST_RUN = 2'b10
	} wdt_state_t;

	// one cpu access: a byte write, a single-bit write or a read
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic byte_wr;
		logic bit_wr;
		logic [2:0] bit_sel;
		logic bit_val;
		logic rd;
	} wdt_bus_req_t;

	// requests toward the cpu core and interrupt controller
	typedef struct packed {
		logic nmi;
		logic sys_reset;
		logic periodic_irq;
		logic periodic_irq_priority;
	} wdt_irq_t;
endpackage : wdt_pkg

// ===== bench/wdt_top_sva.sv
// wdt_top_sva: port checks of the watchdog / interval timer.
// assumes wdt_pkg is compiled first; bound to wdt_top.
`timescale 1ns/1ps
module wdt_top_sva (
	// watched ports
	input wire logic i_clk,
	input wire logic i_srst,
	input wire wdt_pkg::wdt_bus_req_t i_bus,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_valid,
	input wire logic i_stop_standby,
	input wire logic i_periodic_irq_mask,
	input wire wdt_pkg::wdt_irq_t o_irq,
	input wire logic o_watch_clock_sel,
	input wire logic [2:0] o_buzzer_freq_sel
);
	import wdt_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	wire cs_hit = i_bus.addr == WDT_ADDR_CLK_SEL; // clock select decode
	wire run_wr = (i_bus.addr == WDT_ADDR_MODE) && ((i_bus.byte_wr && i_bus.wdata[7]) ||
		(i_bus.bit_wr && i_bus.bit_sel == 3'h7 && i_bus.bit_val)); // restart request
	wire any_req = o_irq.nmi | o_irq.sys_reset | o_irq.periodic_irq;
	// a fresh count needs 256 ticks, so eight quiet cycles is a safe floor
	sequence s_quiet; !any_req [*8]; endsequence
	property p_rdv; i_bus.rd |=> o_rd_valid; endproperty
	a_rdv: assert property (p_rdv) else $error("read answer missing");
	property p_bit3; i_bus.rd && cs_hit |=> !o_rd_data[3]; endproperty
	a_bit3: assert property (p_bit3) else $error("fixed zero bit read as one");
	property p_pass; i_bus.byte_wr && cs_hit |=> {o_watch_clock_sel, o_buzzer_freq_sel} == $past(i_bus.wdata[7:4]); endproperty
	a_pass: assert property (p_pass) else $error("select fields not passed on");
	property p_bitign; i_bus.bit_wr && cs_hit |=> $stable({o_watch_clock_sel, o_buzzer_freq_sel}); endproperty
	a_bitign: assert property (p_bitign) else $error("bit write changed clock select");
	property p_stop; i_stop_standby [*3] |-> !any_req; endproperty
	a_stop: assert property (p_stop) else $error("request during oscillator stop");
	property p_mask; i_periodic_irq_mask [*2] |-> !o_irq.periodic_irq; endproperty
	a_mask: assert property (p_mask) else $error("masked periodic request seen");
	property p_excl; $onehot0({o_irq.nmi, o_irq.sys_reset, o_irq.periodic_irq}); endproperty
	a_excl: assert property (p_excl) else $error("two overflow actions at once");
	property p_restart; run_wr |-> ##2 s_quiet; endproperty
	a_restart: assert property (p_restart) else $error("overflow right after restart");
endmodule : wdt_top_sva
bind wdt_top wdt_top_sva u_wdt_top_sva (.i_clk, .i_srst, .i_bus, .o_rd_data, .o_rd_valid, .i_stop_standby,
	.i_periodic_irq_mask, .o_irq, .o_watch_clock_sel, .o_buzzer_freq_sel);

// ===== bench/wdt_cpu_model.sv
// wdt_cpu_model: core and interrupt side; counts every request pulse it takes.
// assumes one-cycle request pulses synchronous to i_clk; i_clr is the system reset.
`timescale 1ns/1ps
module wdt_cpu_model (
	input wire logic i_clk,
	input wire logic i_clr,
	input wire wdt_pkg::wdt_irq_t i_irq,
	output logic [7:0] o_nmi_cnt,
	output logic [7:0] o_rst_cnt,
	output logic [7:0] o_per_cnt
);
	import wdt_pkg::*;
	// counts clear with the system reset, like the rest of the chip
	always_ff @(posedge i_clk) begin
		if (i_clr) begin
			o_nmi_cnt <= 8'h00;
			o_rst_cnt <= 8'h00;
			o_per_cnt <= 8'h00;
		end else begin
			o_nmi_cnt <= o_nmi_cnt + {7'h00, i_irq.nmi};
			o_rst_cnt <= o_rst_cnt + {7'h00, i_irq.sys_reset};
			o_per_cnt <= o_per_cnt + {7'h00, i_irq.periodic_irq};
		end
	end
endmodule : wdt_cpu_model

// ===== bench/wdt_top_tb_top.sv
// wdt_top_tb_top: self-checking bench of the watchdog / interval timer.
// assumes wdt_pkg, wdt_top, the checker and the cpu model are compiled first.
`timescale 1ns/1ps
module wdt_top_tb_top;
	import wdt_pkg::*;
	localparam int PER = 2 ** (WDT_DIV_BASE + WDT_CNT_W); // code 0 period in main clocks
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic stop = 1'b0;
	logic msk = 1'b0;
	logic sub = 1'b0; // cpu running from the subclock
	logic halt = 1'b0; // idle standby level
	logic prio = 1'b0; // periodic priority flag
	wdt_bus_req_t bus = '0;
	logic [7:0] rdd, nn, nr, np;
	logic rdv, wsel;
	logic [2:0] bsel;
	wdt_irq_t irq;
	int bad_count = 0;
	int n_compared = 0;
	int cyc;
	always #2 clk = ~clk;
	// every status input is driven so that gating and pass-through can be judged
	wdt_top u_wdt_top (.i_clk(clk), .i_srst(srst), .i_bus(bus), .o_rd_data(rdd), .o_rd_valid(rdv),
		.i_halt_standby(halt), .i_stop_standby(stop), .i_cpu_on_subclock(sub), .i_periodic_irq_mask(msk),
		.i_periodic_irq_priority(prio), .o_irq(irq), .o_watch_clock_sel(wsel), .o_buzzer_freq_sel(bsel));
	wdt_cpu_model u_wdt_cpu_model (.i_clk(clk), .i_clr(srst), .i_irq(irq), .o_nmi_cnt(nn), .o_rst_cnt(nr),
		.o_per_cnt(np));
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask : chk
	// every drive lands one ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic rst;
		srst = 1'b1;
		tick(12);
		srst = 1'b0;
	endtask : rst
	// k is {byte_wr, bit_wr, rd}; bit writes take bit d[2:0], value d[3]; reads expect d
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic [2:0] k);
		bus.addr = a;
		bus.wdata = d;
		{bus.byte_wr, bus.bit_wr, bus.rd} = k;
		bus.bit_sel = d[2:0];
		bus.bit_val = d[3];
		tick(1);
		bus = '0;
		if (k == 3'b001) begin
			chk({rdv, rdd}, {1'b1, d});
		end
		tick(1);
	endtask : acc
	// counts edges until request bit b pulses; gives up after lim
	task automatic wait_req(input int b, input int lim);
		cyc = 0;
		do begin
			tick(1);
			cyc++;
			if (cyc > lim) begin
				chk(16'(cyc), 16'(lim));
				end_of_test;
			end
		end while (irq[b] !== 1'b1);
	endtask : wait_req
	task automatic t_regs;
		acc(WDT_ADDR_CLK_SEL, WDT_CLK_SEL_RST, 3'b001);
		acc(WDT_ADDR_MODE, WDT_MODE_RST, 3'b001);
		acc(16'h0000, 8'h00, 3'b001);
		acc(WDT_ADDR_CLK_SEL, 8'hFF, 3'b100);
		chk({wsel, bsel}, 16'h000F);
		acc(WDT_ADDR_CLK_SEL, 8'h04, 3'b010);
		acc(WDT_ADDR_CLK_SEL, 8'hFF & WDT_CLK_SEL_MASK, 3'b001);
		acc(WDT_ADDR_CLK_SEL, 8'h00, 3'b100);
	endtask : t_regs
	task automatic t_interval;
		acc(WDT_ADDR_MODE, 8'h0B, 3'b010);
		acc(WDT_ADDR_MODE, 8'h0F, 3'b010);
		wait_req(1, PER + 50);
		wait_req(1, PER + 50);
		chk(16'(cyc), 16'(PER));
		acc(WDT_ADDR_MODE, 8'h00, 3'b100);
		acc(WDT_ADDR_MODE, 8'h07, 3'b010);
		acc(WDT_ADDR_MODE, 8'h88, 3'b001);
		msk = 1'b1;
		tick(PER + 50);
		chk(np, 8'h02);
		msk = 1'b0;
	endtask : t_interval
	task automatic t_watchdog;
		rst;
		acc(WDT_ADDR_MODE, 8'h90, 3'b100);
		repeat (3) begin
			tick(PER - 500);
			acc(WDT_ADDR_MODE, 8'h80, 3'b100);
		end
		stop = 1'b1;
		tick(PER + 900);
		stop = 1'b0;
		chk(nn, 8'h00);
		wait_req(3, PER + 50);
		rst;
		acc(WDT_ADDR_MODE, 8'h98, 3'b100);
		wait_req(2, PER + 50);
	endtask : t_watchdog
	// code 1 doubles the period; subclock freezes, idle standby and priority do not
	task automatic t_gating;
		rst;
		acc(WDT_ADDR_CLK_SEL, 8'h01, 3'b100);
		acc(WDT_ADDR_MODE, 8'h88, 3'b100);
		wait_req(1, 2 * PER + 50);
		wait_req(1, 2 * PER + 50);
		chk(16'(cyc), 16'(2 * PER));
		sub = 1'b1;
		tick(2 * PER + 50);
		chk(np, 8'h02);
		sub = 1'b0;
		halt = 1'b1;
		prio = 1'b1;
		wait_req(1, 2 * PER + 50);
		chk(16'(irq[0]), 16'h0001);
		halt = 1'b0;
		prio = 1'b0;
	endtask : t_gating
	initial begin
		rst;
		t_regs;
		t_interval;
		t_watchdog;
		t_gating;
		end_of_test;
	end
endmodule : wdt_top_tb_top
